/* hdl/msf_core.sv */
// Purpose: sample buffer modes, data register pops and event flags
// Assumes: register port from the serial front end on core_clk; samples and
//          orientation arrive on the sensor link clock
// Notes:   time registers count in sample ticks taken on the link side
//
// Notes on behaviour
// - inactivity flag when enabled axes stay below threshold past inactivity time
// - free-fall flag when all axes below threshold past fall time, dc
// - watermark flag raised outside bypass while sample count is at or above sample field
// - watermark clears itself once reads bring count below the field
// - bypass: overrun when new sample replaces unread output registers
// - buffered modes: overrun when buffer fills, cleared by reading buffer
// - orientation flag on a move between two different valid orientations
// - no orientation flag entering dead zone or returning to same orientation
// - dimension-select bit picks two- or three-dimensional orientation set
// - 32-entry buffer, four modes from the two-bit mode field
// - bypass keeps buffer empty, samples go straight to output registers
// - fill-and-stop stores samples until 32 held, then stops storing
// - rolling keeps newest 32 samples, dropping the oldest when full
// - triggered rolls until trigger, keeps last n, then fills and stops
// - later triggers ignored until bypass then triggered mode selected again
// - selecting bypass empties the buffer
// - buffered modes: each pop loads oldest sample into output registers
// - single-byte data read discards rest of that buffer entry
// - data read ends on a read of any non-data address (such as the step past last data byte) or select rise
// - flags latch except watermark, which follows count; overrun clears by data reads in buffered modes, others by source read
// - enabled flags drive one of two event pins per mapping bit
`timescale 1ns/1ps
module msf_core (
  // core clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // register port from the serial front end
  input  wire msf_pkg::msf_reg_req_t reg_req,
  input  wire logic                 sel_release,
  output logic [7:0]                reg_rdata,
  // sensor link
  input  wire logic                 link_clk,
  input  wire logic                 sample_valid,
  input  wire msf_pkg::msf_sample_t sample_in,
  input  wire logic [2:0]           orient_2d,
  input  wire logic [2:0]           orient_3d,
  input  wire logic                 fall_below,
  input  wire logic [2:0]           inact_below,
  // event pins
  output logic                      event_pin_one,
  output logic                      event_pin_two
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  logic [7:0] inact_thr_q, inact_time_q, axis_ctl_q, fall_thr_q, fall_time_q;
  logic [7:0] int_en_q, int_map_q, buf_ctl_q, orientation_config_q;
  logic [7:0] inact_thr_d, inact_time_d, axis_ctl_d, fall_thr_d, fall_time_d;
  logic [7:0] int_en_d, int_map_d, buf_ctl_d, orientation_config_d;
  logic [7:0] flags_q, flags_d, rdata_q, rdata_d;
  msf_pkg::msf_sample_t out_q, out_d;
  logic       out_unread_q, out_unread_d;
  logic       reading_q, reading_d;
  logic       armed_q, armed_d, trig_seen_q, trig_seen_d;
  logic       pin1_q, pin1_d, pin2_q, pin2_d;
  logic [2:0] prev_or_q, prev_or_d;
  logic       link_tog_q, link_tog_d;
  msf_pkg::msf_sample_t link_data_q;

  msf_pkg::msf_mode_t mode;
  logic       bypass, pop, flush, keep, new_sample, fall_hit, inact_hit, or_change;
  logic [5:0] count;
  logic [2:0] or_now;
  msf_pkg::msf_sample_t pop_data;

  assign mode   = msf_pkg::msf_mode_t'(buf_ctl_q[msf_pkg::MODE_HI:msf_pkg::MODE_LO]);
  assign bypass = (mode == msf_pkg::MSF_BYPASS);

  function automatic logic is_data(input logic [5:0] a);
    is_data = (a >= msf_pkg::ADDR_DATA_FIRST) && (a <= msf_pkg::ADDR_DATA_LAST);
  endfunction

  // ------------------------------------------------------------------
  // link side: time counters run on sample ticks
  // ------------------------------------------------------------------
  logic [7:0] fall_cnt_q, fall_cnt_d, inact_cnt_q, inact_cnt_d;
  logic       fall_ev, inact_ev;
  logic [7:0] fall_lim_s1_q, fall_lim_q, inact_lim_s1_q, inact_lim_q;
  logic [2:0] inact_en_s1_q, inact_en_q;
  logic       inact_all;

  // limits are quasi-static; software is expected to disable before changing
  assign inact_all = (inact_en_q != 3'h0) && ((inact_below & inact_en_q) == inact_en_q);

  always_comb begin
    link_tog_d  = link_tog_q ^ sample_valid;
    fall_cnt_d  = fall_cnt_q;
    inact_cnt_d = inact_cnt_q;
    fall_ev     = 1'b0;
    inact_ev    = 1'b0;
    if (sample_valid) begin
      // all three axes are always anded, dc-coupled
      if (fall_below) begin
        if (fall_cnt_q == fall_lim_q) begin
          fall_ev = 1'b1;
        end else begin
          fall_cnt_d = fall_cnt_q + 8'h01;
        end
      end else begin
        fall_cnt_d = 8'h00;
      end
      // only enabled axes take part, 255 at most
      if (inact_all) begin
        if (inact_cnt_q == inact_lim_q) begin
          inact_ev = 1'b1;
        end else begin
          inact_cnt_d = inact_cnt_q + 8'h01;
        end
      end else begin
        inact_cnt_d = 8'h00;
      end
    end
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      {link_tog_q, fall_cnt_q, inact_cnt_q, inact_en_s1_q, inact_en_q, link_data_q} <= '0;
      {fall_lim_s1_q, fall_lim_q, inact_lim_s1_q, inact_lim_q} <= '0;
    end else begin
      link_tog_q     <= link_tog_d;
      fall_cnt_q     <= fall_cnt_d;
      inact_cnt_q    <= inact_cnt_d;
      fall_lim_s1_q  <= fall_time_q;
      fall_lim_q     <= fall_lim_s1_q;
      inact_lim_s1_q <= inact_time_q;
      inact_lim_q    <= inact_lim_s1_q;
      inact_en_s1_q  <= axis_ctl_q[2:0];
      inact_en_q     <= inact_en_s1_q;
      if (sample_valid) begin
        link_data_q <= sample_in;
      end
    end
  end

  msf_event_sync u_sample_sync (.src_clk(link_clk), .src_event(sample_valid), .dst_clk(core_clk),
                                .nrst(nrst), .dst_pulse(new_sample));
  msf_event_sync u_fall_sync (.src_clk(link_clk), .src_event(fall_ev), .dst_clk(core_clk),
                              .nrst(nrst), .dst_pulse(fall_hit));
  msf_event_sync u_inact_sync (.src_clk(link_clk), .src_event(inact_ev), .dst_clk(core_clk),
                               .nrst(nrst), .dst_pulse(inact_hit));

  // ------------------------------------------------------------------
  // orientation, held by the link sample and read after the sample pulse
  // ------------------------------------------------------------------
  logic [2:0] or2_q, or3_q;
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      or2_q <= 3'h0;
      or3_q <= 3'h0;
    end else if (sample_valid) begin
      or2_q <= orient_2d;
      or3_q <= orient_3d;
    end
  end

  // set selected by the dimension bit
  assign or_now = orientation_config_q[msf_pkg::DIM_SEL_BIT] ? or3_q : or2_q;
  always_comb begin
    prev_or_d = prev_or_q;
    or_change = 1'b0;
    if (new_sample && or_now != 3'(msf_pkg::MSF_OR_NONE)) begin
      // dead zone neither flags nor forgets the last valid one
      or_change = (prev_or_q != 3'(msf_pkg::MSF_OR_NONE)) && (or_now != prev_or_q);
      prev_or_d = or_now;
    end
  end

  // ------------------------------------------------------------------
  // sample buffer and modes
  // ------------------------------------------------------------------
  logic trig_pulse;
  logic data_read, read_end;

  // trigger follows the registered pin, so it never meets the push of its own sample
  assign trig_pulse = (mode == msf_pkg::MSF_TRIG) && armed_q &&
                      (buf_ctl_q[msf_pkg::TRIG_PIN_BIT] ? pin2_q : pin1_q);
  assign flush      = bypass;
  assign keep       = trig_pulse;
  assign data_read  = reg_req.rd && is_data(reg_req.addr);
  // a read ends on a read of any non-data address, such as the step past the last data byte, or on select release
  assign read_end   = reading_q && (sel_release ||
                      (reg_req.rd && !is_data(reg_req.addr)));
  assign pop        = read_end && !bypass;

  msf_sample_buf u_buf (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .flush     (flush),
    .roll      (mode == msf_pkg::MSF_ROLL ||
                (mode == msf_pkg::MSF_TRIG && !trig_seen_q)),
    .keep_n    ({1'b0, buf_ctl_q[4:0]}),
    .keep      (keep),
    .push      (new_sample && !bypass),
    .push_data (link_data_q),
    .pop       (pop),
    .pop_data  (pop_data),
    .count     (count)
  );

  // ------------------------------------------------------------------
  // register writes, reads and flags
  // ------------------------------------------------------------------
  always_comb begin
    inact_thr_d   = inact_thr_q;
    inact_time_d  = inact_time_q;
    axis_ctl_d    = axis_ctl_q;
    fall_thr_d    = fall_thr_q;
    fall_time_d   = fall_time_q;
    int_en_d      = int_en_q;
    int_map_d     = int_map_q;
    buf_ctl_d     = buf_ctl_q;
    orientation_config_d = orientation_config_q;
    flags_d       = flags_q;
    out_d         = out_q;
    out_unread_d  = out_unread_q;
    reading_d     = (reading_q || data_read) && !read_end;
    armed_d       = armed_q;
    trig_seen_d   = trig_seen_q;
    rdata_d       = msf_pkg::ZERO_BYTE;
    if (reg_req.wr) begin
      if (reg_req.addr == msf_pkg::ADDR_INACT_THRESH) begin
        inact_thr_d = reg_req.wdata;
      end else if (reg_req.addr == msf_pkg::ADDR_INACT_TIME) begin
        inact_time_d = reg_req.wdata;
      end else if (reg_req.addr == msf_pkg::ADDR_AXIS_CTL) begin
        axis_ctl_d = reg_req.wdata;
      end else if (reg_req.addr == msf_pkg::ADDR_FALL_THRESH) begin
        fall_thr_d = reg_req.wdata;
      end else if (reg_req.addr == msf_pkg::ADDR_FALL_TIME) begin
        fall_time_d = reg_req.wdata;
      end else if (reg_req.addr == msf_pkg::ADDR_INT_ENABLE) begin
        int_en_d = reg_req.wdata;
      end else if (reg_req.addr == msf_pkg::ADDR_INT_MAP) begin
        int_map_d = reg_req.wdata;
      end else if (reg_req.addr == msf_pkg::ADDR_BUF_CTL) begin
        buf_ctl_d = reg_req.wdata;
      end else if (reg_req.addr == msf_pkg::ADDR_ORIENTATION_CONFIG) begin
        orientation_config_d = reg_req.wdata;
      end
    end
    // rearm only via bypass, further triggers ignored
    if (bypass) begin
      armed_d     = 1'b1;
      trig_seen_d = 1'b0;
    end else if (trig_pulse) begin
      armed_d     = 1'b0;
      trig_seen_d = 1'b1;
    end
    if (reg_req.rd) begin
      if (reg_req.addr == msf_pkg::ADDR_INACT_THRESH) begin
        rdata_d = inact_thr_q;
      end else if (reg_req.addr == msf_pkg::ADDR_INACT_TIME) begin
        rdata_d = inact_time_q;
      end else if (reg_req.addr == msf_pkg::ADDR_AXIS_CTL) begin
        rdata_d = axis_ctl_q;
      end else if (reg_req.addr == msf_pkg::ADDR_FALL_THRESH) begin
        rdata_d = fall_thr_q;
      end else if (reg_req.addr == msf_pkg::ADDR_FALL_TIME) begin
        rdata_d = fall_time_q;
      end else if (reg_req.addr == msf_pkg::ADDR_INT_ENABLE) begin
        rdata_d = int_en_q;
      end else if (reg_req.addr == msf_pkg::ADDR_INT_MAP) begin
        rdata_d = int_map_q;
      end else if (reg_req.addr == msf_pkg::ADDR_INT_SOURCE) begin
        rdata_d = flags_q;
      end else if (is_data(reg_req.addr)) begin
        rdata_d = out_q[8 * (reg_req.addr - msf_pkg::ADDR_DATA_FIRST) +: 8];
      end else if (reg_req.addr == msf_pkg::ADDR_BUF_CTL) begin
        rdata_d = buf_ctl_q;
      end else if (reg_req.addr == msf_pkg::ADDR_BUF_STATUS) begin
        rdata_d = {2'b00, count};
      end else if (reg_req.addr == msf_pkg::ADDR_ORIENTATION_CONFIG) begin
        rdata_d = orientation_config_q;
      end
    end
    // source read clears non-data flags; a same-cycle set still wins
    if (reg_req.rd && reg_req.addr == msf_pkg::ADDR_INT_SOURCE) begin
      flags_d[msf_pkg::FLAG_INACT]  = 1'b0;
      flags_d[msf_pkg::FLAG_FALL]   = 1'b0;
      flags_d[msf_pkg::FLAG_ORIENT] = 1'b0;
    end
    if (data_read) begin
      out_unread_d = 1'b0;
    end
    if (pop) begin
      out_d                       = pop_data;
      flags_d[msf_pkg::FLAG_OVR]  = 1'b0;
    end
    if (bypass && new_sample) begin
      // direct path; unread outputs being replaced is an overrun
      if (out_unread_q && !data_read) begin
        flags_d[msf_pkg::FLAG_OVR] = 1'b1;
      end
      out_d        = link_data_q;
      out_unread_d = 1'b1;
    end
    // a pop from a full buffer must win, else the flag could never clear
    if (!bypass && !pop && count == 6'(msf_pkg::DEPTH)) begin
      flags_d[msf_pkg::FLAG_OVR] = 1'b1;
    end
    // level follows count against sample field
    flags_d[msf_pkg::FLAG_WMARK] = !bypass && (count >= {1'b0, buf_ctl_q[4:0]});
    if (inact_hit) begin
      flags_d[msf_pkg::FLAG_INACT] = 1'b1;
    end
    if (fall_hit) begin
      flags_d[msf_pkg::FLAG_FALL] = 1'b1;
    end
    if (or_change) begin
      flags_d[msf_pkg::FLAG_ORIENT] = 1'b1;
    end
  end

  // enabled flags onto the mapped pin
  always_comb begin
    pin1_d = |(flags_d & int_en_q & ~int_map_q);
    pin2_d = |(flags_d & int_en_q & int_map_q);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {inact_thr_q, inact_time_q, axis_ctl_q, fall_thr_q, fall_time_q} <= '0;
      {int_en_q, int_map_q, buf_ctl_q, flags_q, rdata_q, out_q} <= '0;
      {out_unread_q, reading_q, trig_seen_q, pin1_q, pin2_q, prev_or_q} <= '0;
      orientation_config_q <= msf_pkg::ORIENTATION_CONFIG_RST;
      armed_q       <= 1'b1;
    end else begin
      inact_thr_q   <= inact_thr_d;
      inact_time_q  <= inact_time_d;
      axis_ctl_q    <= axis_ctl_d;
      fall_thr_q    <= fall_thr_d;
      fall_time_q   <= fall_time_d;
      int_en_q      <= int_en_d;
      int_map_q     <= int_map_d;
      buf_ctl_q     <= buf_ctl_d;
      orientation_config_q <= orientation_config_d;
      flags_q       <= flags_d;
      rdata_q       <= rdata_d;
      out_q         <= out_d;
      out_unread_q  <= out_unread_d;
      reading_q     <= reading_d;
      armed_q       <= armed_d;
      trig_seen_q   <= trig_seen_d;
      pin1_q        <= pin1_d;
      pin2_q        <= pin2_d;
      prev_or_q     <= prev_or_d;
    end
  end

  assign reg_rdata     = rdata_q;
  assign event_pin_one = pin1_q;
  assign event_pin_two = pin2_q;

endmodule

/* hdl/msf_pkg.sv */
// Purpose: shared constants and types for the motion sample buffer and event flags
// Assumes: register port carries 6-bit addresses, 8-bit data
// Notes:   every offset, timing count and field position except the sample and axis-enable bits lives here
package msf_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [5:0] ADDR_INACT_THRESH = 6'h25;
  localparam logic [5:0] ADDR_INACT_TIME   = 6'h26;
  localparam logic [5:0] ADDR_AXIS_CTL     = 6'h27;
  localparam logic [5:0] ADDR_FALL_THRESH  = 6'h28;
  localparam logic [5:0] ADDR_FALL_TIME    = 6'h29;
  localparam logic [5:0] ADDR_INT_ENABLE   = 6'h2e;
  localparam logic [5:0] ADDR_INT_MAP      = 6'h2f;
  localparam logic [5:0] ADDR_INT_SOURCE   = 6'h30;
  localparam logic [5:0] ADDR_DATA_FIRST   = 6'h32;
  localparam logic [5:0] ADDR_DATA_LAST    = 6'h37;
  localparam logic [5:0] ADDR_BUF_CTL      = 6'h38;
  localparam logic [5:0] ADDR_BUF_STATUS   = 6'h39;
  localparam logic [5:0] ADDR_ORIENTATION_CONFIG  = 6'h3b;

  // ------------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------------
  localparam int         MODE_HI         = 7;
  localparam int         MODE_LO         = 6;
  localparam int         TRIG_PIN_BIT    = 5;
  localparam int         DIM_SEL_BIT     = 3;
  localparam int         FLAG_INACT      = 3;
  localparam int         FLAG_FALL       = 2;
  localparam int         FLAG_WMARK      = 1;
  localparam int         FLAG_OVR        = 0;
  localparam int         FLAG_ORIENT     = 7;
  localparam logic [7:0] ORIENTATION_CONFIG_RST = 8'h25;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  localparam int         DEPTH           = 32;
  localparam int         CNT_W           = 6;

  // ------------------------------------------------------------------
  // timing: sample rate ticks, core clock at 200 MHz
  // ------------------------------------------------------------------
  localparam int CLK_MHZ       = 200;
  localparam int POP_DELAY_US  = 5;
  localparam int POP_CYCLES    = POP_DELAY_US * CLK_MHZ;
  localparam int FALL_LSB_MS   = 5;
  localparam int INACT_MAX_SEC = 255;

  typedef enum logic [1:0] {
    MSF_BYPASS, MSF_FILL, MSF_ROLL, MSF_TRIG
  } msf_mode_t;

  typedef enum logic [2:0] {
    MSF_OR_NONE, MSF_OR_XP, MSF_OR_XN, MSF_OR_YP, MSF_OR_YN, MSF_OR_ZP, MSF_OR_ZN
  } msf_orient_t;

  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } msf_sample_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } msf_reg_req_t;

endpackage

/* hdl/msf_event_sync.sv */
// Purpose: move a one-cycle event from the link clock into the core clock
// Assumes: events on the link side are spaced well apart
// Notes:   toggle crossing; second flop only feeds the edge detector
`timescale 1ns/1ps
module msf_event_sync (
  // source domain
  input  wire logic src_clk,
  input  wire logic src_event,
  // destination domain
  input  wire logic dst_clk,
  input  wire logic nrst,
  output logic      dst_pulse
);

  logic tog_q, tog_d;
  logic s1_q, s2_q, s3_q;

  always_comb begin
    tog_d = tog_q ^ src_event;
  end

  always_ff @(posedge src_clk or negedge nrst) begin
    if (!nrst) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= tog_d;
    end
  end

  always_ff @(posedge dst_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= tog_q;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign dst_pulse = s2_q ^ s3_q;

endmodule

/* hdl/msf_sample_buf.sv */
// Purpose: 32-entry store of whole x, y, z samples
// Assumes: at most one push and one pop per cycle
// Notes:   a push to a full store drops the oldest when roll is set
`timescale 1ns/1ps
module msf_sample_buf (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  // control
  input  wire logic                   flush,
  input  wire logic                   roll,
  input  wire logic [5:0]             keep_n,
  input  wire logic                   keep,
  // data
  input  wire logic                   push,
  input  wire msf_pkg::msf_sample_t   push_data,
  input  wire logic                   pop,
  output msf_pkg::msf_sample_t        pop_data,
  output logic [5:0]                  count
);

  msf_pkg::msf_sample_t mem [msf_pkg::DEPTH];
  logic [4:0] rd_q, rd_d;
  logic [4:0] wr_q, wr_d;
  logic [5:0] cnt_q, cnt_d;
  logic       full;
  logic       do_push;

  assign full     = (cnt_q == 6'(msf_pkg::DEPTH));
  assign pop_data = mem[rd_q];
  assign count    = cnt_q;
  assign do_push  = push && (!full || roll);

  always_comb begin
    rd_d  = rd_q;
    wr_d  = wr_q;
    cnt_d = cnt_q;
    if (flush) begin
      rd_d  = 5'h0;
      wr_d  = 5'h0;
      cnt_d = 6'h00;
    end else if (keep) begin
      // drop all but the newest keep_n entries
      if (cnt_q > keep_n) begin
        rd_d  = wr_q - 5'(keep_n);
        cnt_d = keep_n;
      end
    end else begin
      if (do_push) begin
        wr_d = wr_q + 5'h1;
      end
      if ((pop && cnt_q != 6'h00) || (do_push && full)) begin
        rd_d = rd_q + 5'h1;
      end
      if (do_push && !full && !(pop && cnt_q != 6'h00)) begin
        cnt_d = cnt_q + 6'h01;
      end else if (!do_push && pop && cnt_q != 6'h00) begin
        cnt_d = cnt_q - 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_q  <= 5'h0;
      wr_q  <= 5'h0;
      cnt_q <= 6'h00;
    end else begin
      rd_q  <= rd_d;
      wr_q  <= wr_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (do_push && !flush && !keep) begin
      mem[wr_q] <= push_data;
    end
  end

endmodule

/* testbench/msf_link_model.sv */
// Purpose: sensor link partner, one sample per call
// Assumes: calls never overlap; a sample goes out every third link cycle
// Notes:   data is inverted after each pulse so a stale sample never passes
`timescale 1ns/1ps
module msf_link_model (
  // sensor link
  input  wire logic            link_clk,
  output logic                 sample_valid,
  output msf_pkg::msf_sample_t sample_in,
  output logic [2:0]           orient_2d,
  output logic [2:0]           orient_3d,
  output logic                 fall_below,
  output logic [2:0]           inact_below
);
  initial {sample_valid, sample_in, orient_2d, orient_3d, fall_below, inact_below} = '0;
  task automatic send(msf_pkg::msf_sample_t s, logic [2:0] o, logic f);
    @(negedge link_clk) {sample_valid, sample_in, orient_2d, fall_below} = {1'b1, s, o, f};
    inact_below = {3{f}};
    @(negedge link_clk) {sample_valid, sample_in} = {1'b0, ~s};
    @(negedge link_clk);
  endtask
endmodule

/* testbench/msf_core_sva.sv */
// Purpose: port checks on status reads, flag latching and event pins
// Assumes: writes on reg_req mirror enable, map and mode
// Notes:   age counts hide the flag-to-pin pipeline after a write
`timescale 1ns/1ps
module msf_core_sva (
  // clock, reset and register port
  input wire logic                  core_clk,
  input wire logic                  nrst,
  input wire msf_pkg::msf_reg_req_t reg_req,
  input wire logic                  sel_release,
  input wire logic [7:0]            reg_rdata,
  // event pins
  input wire logic                  event_pin_one,
  input wire logic                  event_pin_two
);
  logic [7:0]  en_q, en_d, map_q, map_d;
  logic [1:0]  mode_q, mode_d, age_q, age_d;
  logic [7:0]  qt_q, qt_d;
  always_comb begin
    {en_d, map_d, mode_d} = {en_q, map_q, mode_q};
    age_d = reg_req.wr ? 2'h0 : age_q + 2'(age_q != 2'h3);
    qt_d = (reg_req.rd | reg_req.wr | sel_release) ? 8'h00 : qt_q + 8'(qt_q != 8'hff);
    if (reg_req.wr && reg_req.addr == 6'h2e) en_d = reg_req.wdata;
    if (reg_req.wr && reg_req.addr == 6'h2f) map_d = reg_req.wdata;
    if (reg_req.wr && reg_req.addr == 6'h38) mode_d = reg_req.wdata[7:6];
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) {en_q, map_q, mode_q, age_q, qt_q} <= '0;
    else {en_q, map_q, mode_q, age_q, qt_q} <= {en_d, map_d, mode_d, age_d, qt_d};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_idle; !reg_req.rd |=> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_max; reg_req.rd && reg_req.addr == 6'h39 |=> reg_rdata[5:0] <= 6'h20; endproperty
  a_max: assert property (p_max) else $error("count above depth");
  property p_byp; reg_req.rd && reg_req.addr == 6'h39 && mode_q == 2'h0 && age_q == 2'h3
    |=> reg_rdata[5:0] == 6'h00; endproperty
  a_byp: assert property (p_byp) else $error("bypass buffer not empty");
  property p_wm; reg_req.rd && reg_req.addr == 6'h30 && mode_q == 2'h0 && age_q == 2'h3
    |=> !reg_rdata[1]; endproperty
  a_wm: assert property (p_wm) else $error("watermark in bypass");
  property p_off; age_q == 2'h3 && en_q == 8'h00 |-> !event_pin_one && !event_pin_two; endproperty
  a_off: assert property (p_off) else $error("pin high while disabled");
  property p_one; age_q == 2'h3 && (en_q & ~map_q) == 8'h00 |-> !event_pin_one; endproperty
  a_one: assert property (p_one) else $error("pin one unmapped");
  property p_two; age_q == 2'h3 && (en_q & map_q) == 8'h00 |-> !event_pin_two; endproperty
  a_two: assert property (p_two) else $error("pin two unmapped");
  property p_latch; qt_q == 8'hff && mode_q != 2'h3
    |-> !$fell(event_pin_one) && !$fell(event_pin_two); endproperty
  a_latch: assert property (p_latch) else $error("flag dropped without read");
  c_trig: cover property (reg_req.rd && mode_q == 2'h3);
  c_one: cover property ($rose(event_pin_one));
  c_two: cover property ($rose(event_pin_two));
endmodule
bind msf_core msf_core_sva i_msf_core_sva (.*);

/* testbench/test_motion_sample_fifo_events.sv */
// Purpose: directed bench for buffer modes and event flags
// Assumes: host waits the pop delay after every data read
// Notes:   first burst after a change to a buffered mode only primes the output registers
`timescale 1ns/1ps
module test_motion_sample_fifo_events;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
  logic                  core_clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, sel_release = 1'b0;
  msf_pkg::msf_reg_req_t reg_req = '0;
  msf_pkg::msf_sample_t  sample_in;
  logic [7:0]            reg_rdata, d;
  logic [47:0]           q;
  logic [2:0]            orient_2d, orient_3d, inact_below;
  logic                  sample_valid, fall_below, event_pin_one, event_pin_two;
  int                    failures = 0, compares = 0, cyc = 0;
  msf_core       i_msf_core (.*);
  msf_link_model i_msf_link_model (.*);
  always #2.5 core_clk = ~core_clk;
  initial begin #1.3; forever #62.5 link_clk = ~link_clk; end
  function automatic msf_pkg::msf_sample_t smp(int i);
    return {16'h0300 + 16'(i), 16'h0200 + 16'(i), 16'h0100 + 16'(i)};
  endfunction
  task automatic rd(logic [5:0] a);
    @(negedge core_clk) reg_req = {2'b01, a, 8'h00};
    @(negedge core_clk) reg_req = '0;
    d = reg_rdata;
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] v);
    @(negedge core_clk) reg_req = {2'b10, a, v};
    @(negedge core_clk) reg_req = '0;
  endtask
  task automatic hold;
    repeat (msf_pkg::POP_CYCLES) @(negedge core_clk);
  endtask
  task automatic pop;
    for (int i = 0; i < 6; i++) begin
      rd(6'h32 + 6'(i));
      q[8*i +: 8] = d;
    end
    rd(6'h38); // stepping past the last data byte ends the read
    hold();
  endtask
  task automatic feed(int n, logic f);
    for (int i = 0; i < n; i++) i_msf_link_model.send(smp(i), 3'h1, f);
    repeat (20) @(negedge core_clk);
  endtask
  task automatic t_fill;
    wr(6'h38, 8'h5f);
    feed(33, 1'b0);
    rd(6'h39);
    `CHK("count", 6'h20, d[5:0])
    rd(6'h30);
    `CHK("src", 2'b11, d[1:0])
    pop();
    rd(6'h30);
    `CHK("src", 2'b10, d[1:0])
    pop();
    `CHK("entry", smp(0), q)
    rd(6'h30);
    `CHK("wmark", 1'b0, d[1])
    $display("fill done");
  endtask
  task automatic t_roll;
    wr(6'h38, 8'h00);
    hold();
    rd(6'h39);
    `CHK("count", 6'h00, d[5:0])
    wr(6'h38, 8'h80);
    feed(34, 1'b0);
    pop();
    rd(6'h32);
    `CHK("x_lo", 8'h02, d)
    @(negedge core_clk) sel_release = 1'b1;
    @(negedge core_clk) sel_release = 1'b0;
    hold();
    pop();
    `CHK("entry", smp(3), q)
    $display("roll done");
  endtask
  task automatic t_bypass;
    wr(6'h38, 8'h00);
    i_msf_link_model.send(smp(7), 3'h1, 1'b0);
    pop();
    `CHK("direct", smp(7), q)
    feed(2, 1'b0);
    rd(6'h30);
    `CHK("ovr", 1'b1, d[0])
    $display("bypass done");
  endtask
  task automatic t_trig;
    wr(6'h29, 8'h00);
    wr(6'h27, 8'h07);
    wr(6'h2f, 8'h00);
    wr(6'h2e, 8'h04);
    wr(6'h38, 8'hc4);
    feed(10, 1'b0);
    feed(1, 1'b1);
    `CHK("pin_one", 1'b1, event_pin_one)
    hold();
    rd(6'h39);
    `CHK("kept", 6'h04, d[5:0])
    rd(6'h30);
    `CHK("src", 2'b11, d[3:2])
    feed(1, 1'b1);
    hold();
    rd(6'h39);
    `CHK("kept", 6'h05, d[5:0])
    $display("trigger done");
  endtask
  task automatic t_orient;
    wr(6'h38, 8'h00);
    wr(6'h2f, 8'h80);
    wr(6'h2e, 8'h80);
    rd(6'h3b);
    `CHK("orient_config", 8'h25, d)
    i_msf_link_model.send(smp(0), 3'h0, 1'b0);
    i_msf_link_model.send(smp(0), 3'h1, 1'b0);
    `CHK("pin_two", 1'b0, event_pin_two)
    i_msf_link_model.send(smp(0), 3'h3, 1'b0);
    `CHK("pin_two", 1'b1, event_pin_two)
    $display("orient done");
  endtask
  task automatic summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      summarize();
    end
  end
  // reset spans link edges too, so the link side clears as well
  initial begin
    repeat (4) @(negedge link_clk);
    @(negedge core_clk) nrst = 1'b1;
    t_fill();
    t_roll();
    t_bypass();
    t_trig();
    t_orient();
    summarize();
  end
endmodule
